// >>> hdl/banked_data_memory_access.v
// Data memory address logic: special registers, banked RAM, indirect windows.
// Assumes the core issues one access per cycle, synchronous to sys_clk.
`timescale 1ns/100ps
`include "data_mem_defs.vh"
module banked_data_memory_access #(
   parameter BANKS = `BANKS_DEFAULT,
   parameter BANK_BITS = 2
) (
   // Clock and reset
   input wire sys_clk,
   input wire rst_n,
   // Watchdog reset taken while powered down keeps the bank
   input wire wdt_sleep_reset,
   // Core access port
   input wire acc_req,
   input wire acc_we,
   input wire [7:0] acc_addr,
   input wire [1:0] acc_op,
   input wire [2:0] acc_bit,
   input wire [7:0] acc_wdata,
   input wire acc_from_alu,
   input wire [7:0] alu_result,
   // Read-only status value from the core
   input wire [7:0] status_in,
   // Read answer
   output reg [7:0] acc_rdata,
   output reg acc_rvalid,
   // Accumulator, bank select and display drive
   output reg [7:0] working_accumulator,
   output reg [7:0] data_bank_select,
   output reg disp_we,
   output reg [5:0] disp_addr,
   output reg [7:0] disp_data
);
   // Operation codes for the access
   localparam OP_BYTE = 2'b00;
   localparam OP_SET = 2'b01;
   localparam OP_CLR = 2'b10;

   // Access states, one-hot
   localparam ST_IDLE = 3'b001;
   localparam ST_READ = 3'b010;
   localparam ST_WRITE = 3'b100;

   reg [2:0] state_reg; // Kind of access taken at the last edge
   reg [2:0] state_next; // Kind of access presented now
   reg [7:0] pointer_zero_reg;
   reg [7:0] pointer_one_reg;
   reg [7:0] disp_mem [0:`DISP_LAST-`GP_BASE];

   // ****************************************
   // Helper functions
   // ****************************************
   // Single-bit set or clear merge on a read byte
   function [7:0] merge_bits;
      input [1:0] op;
      input [2:0] bitn;
      input [7:0] old;
      input [7:0] newv;
      reg [7:0] mask;
      begin
         mask = 8'h01 << bitn;
         if (op == OP_SET) begin
            merge_bits = old | mask;
         end else if (op == OP_CLR) begin
            merge_bits = old & ~mask;
         end else begin
            merge_bits = newv;
         end
      end
   endfunction

   // Bank field masked to implemented bits
   function [1:0] bank_field;
      input [7:0] v;
      begin
         if (BANK_BITS == 1) begin
            bank_field = {1'b0, v[`BANK_FIELD_LO]};
         end else begin
            bank_field = v[`BANK_FIELD_HI:`BANK_FIELD_LO];
         end
      end
   endfunction

   // Kind of access presented this cycle, for the state machine
   function [2:0] next_access;
      input req;
      input we;
      begin
         if (!req) begin
            next_access = ST_IDLE;
         end else if (we) begin
            next_access = ST_WRITE;
         end else begin
            next_access = ST_READ;
         end
      end
   endfunction

   // ****************************************
   // Effective address resolution
   // ****************************************
   reg is_win0;
   reg is_win1;
   reg indirect;
   reg [7:0] eff_addr;
   reg [1:0] eff_bank;
   reg win_target;

   // Work out the final bank and offset of this access
   always @* begin
      is_win0 = (acc_addr == `ADDR_WINDOW_ZERO);
      is_win1 = (acc_addr == `ADDR_WINDOW_ONE);
      indirect = is_win0 | is_win1;
      if (is_win0) begin
         eff_addr = pointer_zero_reg;
         eff_bank = 2'b00;
      end else if (is_win1) begin
         eff_addr = pointer_one_reg;
         eff_bank = bank_field(data_bank_select);
      end else begin
         eff_addr = acc_addr;
         eff_bank = 2'b00;
      end
      // A pointer aimed at a window itself touches nothing
      win_target = indirect & ((eff_addr == `ADDR_WINDOW_ZERO) |
                               (eff_addr == `ADDR_WINDOW_ONE));
   end

   // ****************************************
   // Region decode
   // ****************************************
   reg in_gp;
   reg in_disp;
   reg [8:0] ram_addr;
   wire [7:0] ram_rdata;

   // Special area is below the general base in every bank
   always @* begin
      in_gp = 1'b0;
      in_disp = 1'b0;
      ram_addr = 9'h000;
      if (eff_addr >= `GP_BASE) begin
         if (eff_bank == 2'b01) begin
            in_disp = (eff_addr <= `DISP_LAST);
         end else if ({30'h0000_0000, eff_bank} < BANKS) begin
            in_gp = 1'b1;
            ram_addr = {eff_bank, eff_addr[6:0]};
         end
      end
   end

   // ****************************************
   // Read data selection
   // ****************************************
   reg [7:0] rd_byte;
   reg [5:0] disp_idx;

   // Special register decode, unused addresses read as zero
   always @* begin
      disp_idx = eff_addr[5:0]; // Region base has all six low bits clear
      rd_byte = `ZERO_BYTE;
      if (win_target) begin
         rd_byte = `ZERO_BYTE;
      end else if (in_gp) begin
         rd_byte = ram_rdata;
      end else if (in_disp) begin
         rd_byte = disp_mem[disp_idx];
      end else if (eff_addr >= `GP_BASE) begin
         rd_byte = `ZERO_BYTE;
      end else if (eff_addr == `ADDR_POINTER_ZERO) begin
         rd_byte = pointer_zero_reg;
      end else if (eff_addr == `ADDR_POINTER_ONE) begin
         rd_byte = pointer_one_reg;
      end else if (eff_addr == `ADDR_BANK_SELECT) begin
         rd_byte = data_bank_select;
      end else if (eff_addr == `ADDR_ACCUMULATOR) begin
         rd_byte = working_accumulator;
      end else if (eff_addr == `ADDR_STATUS_RO) begin
         rd_byte = status_in;
      end else begin
         rd_byte = `ZERO_BYTE;
      end
   end

   // ****************************************
   // Write data formation
   // ****************************************
   reg [7:0] src_byte;
   reg [7:0] wr_byte;
   reg do_write;

   // Written data is the access write data or the ALU result, or the read byte with one bit set or cleared
   always @* begin
      src_byte = acc_from_alu ? alu_result : acc_wdata;
      wr_byte = merge_bits(acc_op, acc_bit, rd_byte, src_byte);
      do_write = acc_req & acc_we & ~win_target;
   end

   // General purpose storage for every bank except bank 1, which maps to the display memory
   gp_ram_bank #(
      .BANKS(BANKS)
   ) u_ram (
      .sys_clk(sys_clk),
      .wr_en(do_write & in_gp),
      .wr_addr(ram_addr),
      .wr_data(wr_byte),
      .rd_addr(ram_addr),
      .rd_data(ram_rdata)
   );

   // ****************************************
   // Access state machine
   // ****************************************
   // Read and write cycles are told apart; the read strobe follows the read state
   always @* begin
      case (state_reg)
         ST_IDLE: begin
            state_next = next_access(acc_req, acc_we);
         end
         ST_READ: begin
            state_next = next_access(acc_req, acc_we);
         end
         ST_WRITE: begin
            state_next = next_access(acc_req, acc_we);
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // State register; reset drops any access in flight
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ****************************************
   // Read answer
   // ****************************************
   // Read data is caught at the taking edge and held until the next read
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         acc_rdata <= `ZERO_BYTE;
         acc_rvalid <= 1'b0;
      end else begin
         // One-cycle strobe for each read taken
         acc_rvalid <= (state_next == ST_READ);
         if (state_next == ST_READ) begin
            acc_rdata <= rd_byte;
         end
      end
   end

   // ****************************************
   // Special register writes
   // ****************************************
   // Write strobe for the special section; the status address has no target
   wire sp_write;
   assign sp_write = do_write & ~in_gp & ~in_disp & (eff_addr < `GP_BASE);

   // Memory pointers behave as plain read-write registers
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         pointer_zero_reg <= `ZERO_BYTE;
         pointer_one_reg <= `ZERO_BYTE;
      end else if (sp_write) begin
         if (eff_addr == `ADDR_POINTER_ZERO) begin
            pointer_zero_reg <= wr_byte;
         end else if (eff_addr == `ADDR_POINTER_ONE) begin
            pointer_one_reg <= wr_byte;
         end
      end
   end

   // Bank select; a watchdog reset taken while asleep leaves it as it was
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         if (!wdt_sleep_reset) begin
            data_bank_select <= `BANK_SELECT_RESET;
         end
      end else if (sp_write & (eff_addr == `ADDR_BANK_SELECT)) begin
         // Shared with program banking; only the bank bits are stored
         data_bank_select <= {6'h00, bank_field(wr_byte)};
      end
   end

   // Accumulator; a store to it and an ALU load never meet in one cycle
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         working_accumulator <= `ZERO_BYTE;
      end else if (sp_write & (eff_addr == `ADDR_ACCUMULATOR)) begin
         working_accumulator <= wr_byte;
      end else if (acc_from_alu & ~(acc_req & acc_we)) begin
         // ALU results land here when acc_from_alu is set and the cycle is not a store
         working_accumulator <= alu_result;
      end
   end

   // ****************************************
   // Display memory and drive
   // ****************************************
   // Segment bytes; no reset, the display is rewritten by software
   always @(posedge sys_clk) begin
      if (rst_n & do_write & in_disp) begin
         disp_mem[disp_idx] <= wr_byte;
      end
   end

   // Every stored segment byte is also sent to the display at once
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         disp_we <= 1'b0;
         disp_addr <= 6'h00;
         disp_data <= `ZERO_BYTE;
      end else begin
         disp_we <= do_write & in_disp;
         if (do_write & in_disp) begin
            disp_addr <= disp_idx;
            disp_data <= wr_byte;
         end
      end
   end
endmodule // banked_data_memory_access

// >>> hdl/data_mem_defs.vh
// Constants for the banked data memory access block: addresses, fields, resets.
// Assumes inclusion by bare name from the design files under hdl/.
`ifndef DATA_MEM_DEFS_VH
`define DATA_MEM_DEFS_VH
// ****************************************
// Special purpose addresses (bank independent)
// ****************************************
`define ADDR_WINDOW_ZERO 8'h00
`define ADDR_POINTER_ZERO 8'h01
`define ADDR_WINDOW_ONE 8'h02
`define ADDR_POINTER_ONE 8'h03
`define ADDR_BANK_SELECT 8'h04
`define ADDR_ACCUMULATOR 8'h05
`define ADDR_STATUS_RO 8'h06
// ****************************************
// Region boundaries
// ****************************************
`define GP_BASE 8'h80
`define DISP_LAST 8'hB0
// ****************************************
// Field layout and reset values
// ****************************************
`define BANK_FIELD_HI 1
`define BANK_FIELD_LO 0
`define BANK_SELECT_RESET 8'h00
`define ZERO_BYTE 8'h00
`define BANKS_DEFAULT 4
`endif

// >>> hdl/gp_ram_bank.v
// Byte-wide general purpose storage for all banks, one write and one read port.
// Assumes the caller masks writes and selects the bank; read is combinational.
`timescale 1ns/100ps
module gp_ram_bank #(
   parameter BANKS = 4
) (
   // Clock
   input wire sys_clk,
   // Write port
   input wire wr_en,
   input wire [8:0] wr_addr,
   input wire [7:0] wr_data,
   // Read port
   input wire [8:0] rd_addr,
   output wire [7:0] rd_data
);
   // Storage, 128 bytes per bank
   reg [7:0] mem [0:BANKS*128-1];

   // ****************************************
   // Write process
   // ****************************************
   always @(posedge sys_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Read without latency
   assign rd_data = mem[rd_addr];
endmodule // gp_ram_bank

// >>> dv/bdma_monitor.sv
// Checker for the banked data memory block, watching its top ports.
// Assumes sync active-low reset and at most one access per cycle.
`timescale 1ns/100ps
module bdma_monitor (
   // Clock and reset
   input wire sys_clk,
   input wire rst_n,
   input wire wdt_sleep_reset,
   // Core access
   input wire acc_req,
   input wire acc_we,
   input wire [7:0] acc_addr,
   input wire [1:0] acc_op,
   input wire [7:0] acc_wdata,
   input wire acc_from_alu,
   input wire [7:0] status_in,
   // Answers
   input wire [7:0] acc_rdata,
   input wire acc_rvalid,
   input wire [7:0] data_bank_select,
   input wire disp_we
);
   // ****
   // Helpers
   // ****
   wire rd = acc_req && !acc_we;
   wire bw = acc_req && acc_we && acc_op == 2'h0 && !acc_from_alu;
   wire [1:0] wlo = acc_wdata[1:0];
   // ****
   // Assertions
   // ****
   rd_answer_a:
   assert property (@(posedge sys_clk) disable iff (!rst_n) rd |=> acc_rvalid) else $error("no read answer");
   rd_only_a:
   assert property (@(posedge sys_clk) disable iff (!rst_n) !rd |=> !acc_rvalid) else $error("stray answer");
   bank_upper_a:
   assert property (@(posedge sys_clk) disable iff (!rst_n) data_bank_select[7:2] == 6'h00) else $error("upper bits");
   bank_write_a:
   assert property (@(posedge sys_clk) disable iff (!rst_n) bw && acc_addr == 8'h04
      |=> data_bank_select == {6'h00, $past(wlo)}) else $error("bank write");
   bank_clear_a:
   assert property (@(posedge sys_clk) !rst_n && !wdt_sleep_reset |=> data_bank_select == 8'h00) else $error("bank reset");
   bank_keep_a:
   assert property (@(posedge sys_clk) !rst_n && wdt_sleep_reset |=> $stable(data_bank_select)) else $error("bank lost");
   unused_zero_a:
   assert property (@(posedge sys_clk) disable iff (!rst_n) rd && acc_addr == 8'h07 |=> acc_rdata == 8'h00) else $error("unused");
   status_ro_a:
   assert property (@(posedge sys_clk) disable iff (!rst_n) rd && acc_addr == 8'h06
      |=> acc_rdata == $past(status_in)) else $error("status read");
   direct_bank0_a:
   assert property (@(posedge sys_clk) disable iff (!rst_n) acc_req && acc_we && acc_addr[7] |=> !disp_we) else $error("direct disp");
endmodule // bdma_monitor
bind banked_data_memory_access bdma_monitor u_mon (.sys_clk, .rst_n, .wdt_sleep_reset, .acc_req,
   .acc_we, .acc_addr, .acc_op, .acc_wdata, .acc_from_alu, .status_in, .acc_rdata, .acc_rvalid,
   .data_bank_select, .disp_we);

// >>> dv/core_model.sv
// Core model: issues one data memory access at a time, as the processor would.
// Assumes the testbench calls go; the idle address is scrambled, while we, op and bit are held.
`timescale 1ns/100ps
module core_model (
   // Clock
   input wire sys_clk,
   // Access drive
   output reg acc_req,
   output reg acc_we,
   output reg [7:0] acc_addr,
   output reg [1:0] acc_op,
   output reg [2:0] acc_bit,
   output reg [7:0] acc_wdata,
   output reg acc_from_alu,
   output reg [7:0] alu_result,
   // Read answer
   input wire [7:0] acc_rdata
);
   // Quiet at time zero
   initial begin
      {acc_req, acc_we, acc_addr, acc_op, acc_bit, acc_wdata, acc_from_alu, alu_result} = 0;
   end
   // Launch after an edge, hold through the taking edge, take the answer
   task go(input w, input [7:0] a, input [1:0] o, input [2:0] b, input [7:0] d, input f,
      output [7:0] q);
      begin
         @(posedge sys_clk);
         #1;
         {acc_req, acc_we, acc_addr, acc_op, acc_bit, acc_from_alu} = {1'h1, w, a, o, b, f};
         // Only the chosen source carries d
         acc_wdata = f ? ~d : d;
         alu_result = f ? d : ~d;
         @(posedge sys_clk);
         #1;
         q = acc_rdata;
         // Released address shows no stale value; the data lines change only when f is clear
         {acc_req, acc_from_alu, acc_addr, acc_wdata, alu_result} = {2'h0, ~a, ~d, d};
      end
   endtask
endmodule // core_model

// >>> dv/testbench.sv
// Testbench: drives the core model through each data memory scenario.
// Assumes the design, core model and checker compile alongside.
`timescale 1ns/100ps
module testbench;
   // ****
   // Signals
   // ****
   reg sys_clk;
   reg rst_n;
   reg wdt_sleep_reset;
   reg [7:0] status_in;
   reg [7:0] q;
   wire acc_req, acc_we, acc_from_alu, acc_rvalid, disp_we;
   wire [7:0] acc_addr, acc_wdata, alu_result, acc_rdata, working_accumulator;
   wire [7:0] data_bank_select, disp_data;
   wire [1:0] acc_op;
   wire [2:0] acc_bit;
   wire [5:0] disp_addr;
   integer errors;
   integer compares;
   banked_data_memory_access DUT (.sys_clk, .rst_n, .wdt_sleep_reset, .acc_req, .acc_we,
      .acc_addr, .acc_op, .acc_bit, .acc_wdata, .acc_from_alu, .alu_result, .status_in,
      .acc_rdata, .acc_rvalid, .working_accumulator, .data_bank_select, .disp_we, .disp_addr,
      .disp_data);
   core_model u_core (.sys_clk, .acc_req, .acc_we, .acc_addr, .acc_op, .acc_bit, .acc_wdata,
      .acc_from_alu, .alu_result, .acc_rdata);
   // Clock, 8 ns
   initial begin
      sys_clk = 1'h0;
      forever #4 sys_clk = ~sys_clk;
   end
   // ****
   // Helpers
   // ****
   task cmp(input [7:0] got, input [7:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      u_core.go(1'h1, a, 2'h0, 3'h0, d, 1'h0, q);
   endtask
   task rd(input [7:0] a, input [7:0] e);
      begin
         u_core.go(1'h0, a, 2'h0, 3'h0, 8'h00, 1'h0, q);
         cmp(q, e);
      end
   endtask
   // Reset for 16 cycles, k marks a sleep watchdog reset
   task rst(input k);
      begin
         rst_n = 1'h0;
         wdt_sleep_reset = k;
         repeat (16) @(posedge sys_clk);
         #1;
         rst_n = 1'h1;
         wdt_sleep_reset = 1'h0;
      end
   endtask
   // ****
   // Scenarios
   // ****
   task t_storage;
      begin
         wr(8'h80, 8'h55);
         rd(8'h80, 8'h55);
         cmp({7'h00, acc_rvalid}, 8'h01);
         u_core.go(1'h1, 8'h80, 2'h1, 3'h1, 8'h00, 1'h0, q);
         rd(8'h80, 8'h57);
         u_core.go(1'h1, 8'h80, 2'h2, 3'h0, 8'h00, 1'h0, q);
         rd(8'h80, 8'h56);
      end
   endtask
   task t_indirect;
      begin
         wr(8'h01, 8'h90);
         rd(8'h01, 8'h90);
         wr(8'h00, 8'h33);
         rd(8'h90, 8'h33);
         wr(8'h04, 8'h02);
         rd(8'h00, 8'h33);
         wr(8'h81, 8'hAA);
         wr(8'h03, 8'h81);
         wr(8'h02, 8'h11);
         rd(8'h81, 8'hAA);
         rd(8'h02, 8'h11);
         wr(8'h04, 8'h00);
         rd(8'h02, 8'hAA);
         wr(8'h01, 8'h02);
         rd(8'h00, 8'h00);
         wr(8'h00, 8'hFF);
         rd(8'h81, 8'hAA);
         rd(8'h02, 8'hAA);
      end
   endtask
   task t_display;
      begin
         wr(8'h04, 8'h01);
         wr(8'h02, 8'hC3);
         cmp({7'h00, disp_we}, 8'h01);
         cmp({2'h0, disp_addr}, 8'h01);
         cmp(disp_data, 8'hC3);
         rd(8'h02, 8'hC3);
         cmp({7'h00, disp_we}, 8'h00);
      end
   endtask
   task t_bank;
      begin
         wr(8'h04, 8'hFF);
         rd(8'h04, 8'h03);
         wr(8'h02, 8'h5A);
         rd(8'h02, 8'h5A);
         wr(8'h04, 8'h02);
         rd(8'h02, 8'h11);
      end
   endtask
   task t_special;
      begin
         wr(8'h03, 8'h04);
         rd(8'h02, 8'h02);
         wr(8'h03, 8'h07);
         rd(8'h02, 8'h00);
         wr(8'h06, 8'h00);
         rd(8'h06, 8'hA5);
         wr(8'h07, 8'h12);
         rd(8'h07, 8'h00);
      end
   endtask
   task t_acc;
      begin
         wr(8'h05, 8'h3C);
         cmp(working_accumulator, 8'h3C);
         u_core.go(1'h1, 8'h90, 2'h0, 3'h0, 8'h5A, 1'h1, q);
         rd(8'h90, 8'h5A);
      end
   endtask
   task t_wdt;
      begin
         rst(1'h1);
         rd(8'h04, 8'h02);
         rst(1'h0);
         rd(8'h04, 8'h00);
      end
   endtask
   // Verdict and end of run
   task close_out;
      begin
         if (errors == 0 && compares > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // Main sequence
   initial begin
      errors = 0;
      compares = 0;
      status_in = 8'hA5;
      rst(1'h0);
      cmp(data_bank_select, 8'h00);
      t_storage;
      t_indirect;
      t_display;
      t_bank;
      t_special;
      t_acc;
      t_wdt;
      close_out;
   end
endmodule // testbench
